// *** src/ivp_pkg.sv ***
`default_nettype none
package ivp_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int NSRC     = 16;
    localparam int VEC_W    = 7;
    localparam int PRI_W    = 5;
    localparam int IDX_W    = 4;

    // ****************************************
    // flag and mask bit positions
    // ****************************************
    localparam int BIT_EXT0   = 0;
    localparam int BIT_WDOG   = 1;
    localparam int BIT_EXT2   = 2;
    localparam int BIT_TIMER  = 3;
    localparam int BIT_P0RX   = 4;
    localparam int BIT_P0TX   = 5;
    localparam int BIT_P2RX   = 6;
    localparam int BIT_P2TX   = 7;
    localparam int BIT_EXT3   = 8;
    localparam int BIT_HOST   = 9;
    localparam int BIT_P1RX   = 10;
    localparam int BIT_P1TX   = 11;
    localparam int BIT_DMA4   = 12;
    localparam int BIT_DMA5   = 13;

    // ****************************************
    // vector locations relative to vector base
    // ****************************************
    localparam logic [VEC_W-1:0] VEC_RESET = 7'h00;
    localparam logic [VEC_W-1:0] VEC_NMI   = 7'h04;
    localparam logic [VEC_W-1:0] VEC_RSV_LO = 7'h78;
    localparam logic [VEC_W-1:0] VEC_RSV_HI = 7'h7f;

    // vector and priority per flag bit; unused bits hold vector 00h and priority 1fh
    localparam logic [VEC_W-1:0] VEC_TAB [NSRC] = '{
        7'h40, 7'h44, 7'h48, 7'h4c, 7'h50, 7'h54, 7'h58, 7'h5c,
        7'h60, 7'h64, 7'h68, 7'h6c, 7'h70, 7'h74, 7'h00, 7'h00};
    localparam logic [PRI_W-1:0] PRI_TAB [NSRC] = '{
        5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
        5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h1f, 5'h1f};
    localparam logic [PRI_W-1:0] PRI_RESET = 5'h01;
    localparam logic [PRI_W-1:0] PRI_NONE  = 5'h1f;

    // bits that exist in the flag and mask registers
    localparam logic [NSRC-1:0] IRQ_BITS = 16'h3fff;
    localparam logic [NSRC-1:0] FLAG_RST = 16'h0000;
    localparam logic [NSRC-1:0] MASK_RST = 16'h0000;

    typedef enum logic [1:0] {
        IVP_IDLE  = 2'b00,
        IVP_RESET = 2'b01,
        IVP_SERVE = 2'b10
    } ivp_state_e;
endpackage
`default_nettype wire

// *** src/ivp_prio_sel.sv ***
`default_nettype none
module ivp_prio_sel
    import ivp_pkg::*;
(
    ivp_sel_if.sel s
);
    // ****************************************
    // smallest priority number wins
    // ****************************************
    always_comb begin
        s.hit = 1'b0;
        s.idx = '0;
        // scan downward so the lowest bit (best priority) is left last
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (s.active[i]) begin
                s.hit = 1'b1;
                s.idx = IDX_W'(i);
            end
        end
    end
endmodule
`default_nettype wire

// *** src/ivp_sel_if.sv ***
`default_nettype none
interface ivp_sel_if;
    import ivp_pkg::*;
    logic [NSRC-1:0]  active;
    logic             hit;
    logic [IDX_W-1:0] idx;
    modport src (output active, input hit, input idx);
    modport sel (input active, output hit, output idx);
endinterface
`default_nettype wire

// *** src/ivp_top.sv ***
// Function
// - every source has a fixed relative vector and a fixed priority
// - each subsystem instantiates its own copy of this map
// - hard and soft reset vector to 00, priority 1, highest
// - port 0 receive vectors to 50h, priority 7
// - port 0 transmit vectors to 54h, priority 8
// - 58h priority 9 shared by port 2 receive and DMA 0
// - 5Ch priority 10 shared by port 2 second source and DMA 1
// - host port vectors to 64h priority 12, from host-to-core bit
// - 68h priority 13 shared by port 1 receive and DMA 2
// - 6Ch priority 14 shared by port 1 transmit and DMA 3
// - flag and mask bit 13 is DMA 5, bit 12 is DMA 4
// - bit 1 is watchdog, bit 3 timer; 1 means pending or enabled
`default_nettype none
module ivp_top
    import ivp_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic             hard_reset_input,
    input  wire logic             soft_reset_trap,
    input  wire logic             ext0_irq,
    input  wire logic             watchdog_irq,
    input  wire logic             ext2_irq,
    input  wire logic             timer_irq,
    input  wire logic             port0_receive_irq,
    input  wire logic             port0_transmit_irq,
    input  wire logic             port2_receive_irq,
    input  wire logic             port2_second_irq,
    input  wire logic             ext3_irq,
    input  wire logic             host_to_core_irq_bit,
    input  wire logic             port1_receive_irq,
    input  wire logic             port1_transmit_irq,
    input  wire logic             dma_ch0_irq,
    input  wire logic             dma_ch1_irq,
    input  wire logic             dma_ch2_irq,
    input  wire logic             dma_ch3_irq,
    input  wire logic             dma_ch4_irq,
    input  wire logic             dma_ch5_irq,
    input  wire logic             mask_we,
    input  wire logic [NSRC-1:0]  mask_wdata,
    input  wire logic             flag_clr_we,
    input  wire logic [NSRC-1:0]  flag_clr_data,
    input  wire logic             global_en,
    input  wire logic             vec_ack,
    output logic [NSRC-1:0]       irq_flag_reg,
    output logic [NSRC-1:0]       irq_mask_reg,
    output logic                  vec_req,
    output logic [VEC_W-1:0]      vec_loc,
    output logic [PRI_W-1:0]      vec_pri,
    output logic                  vec_is_reset
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [NSRC-1:0] raw_src;
    logic [NSRC-1:0] sync1;
    logic [NSRC-1:0] sync2;
    logic [NSRC-1:0] src_q;
    logic [1:0]      rst1;
    logic [1:0]      rst2;

    always_comb begin
        raw_src                   = '0;
        raw_src[BIT_EXT0]         = ext0_irq;
        raw_src[BIT_WDOG]         = watchdog_irq;
        raw_src[BIT_EXT2]         = ext2_irq;
        raw_src[BIT_TIMER]        = timer_irq;
        raw_src[BIT_P0RX]         = port0_receive_irq;
        raw_src[BIT_P0TX]         = port0_transmit_irq;
        // shared vectors: either source of the pair sets the one bit
        raw_src[BIT_P2RX]  = port2_receive_irq | dma_ch0_irq;
        raw_src[BIT_P2TX]  = port2_second_irq | dma_ch1_irq;
        raw_src[BIT_EXT3]         = ext3_irq;
        raw_src[BIT_HOST]         = host_to_core_irq_bit;
        raw_src[BIT_P1RX]  = port1_receive_irq | dma_ch2_irq;
        raw_src[BIT_P1TX]  = port1_transmit_irq | dma_ch3_irq;
        raw_src[BIT_DMA4]         = dma_ch4_irq;
        raw_src[BIT_DMA5]         = dma_ch5_irq;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
            src_q <= '0;
            rst1  <= '0;
            rst2  <= '0;
        end else if (clk_en) begin
            sync1 <= raw_src;
            sync2 <= sync1;
            src_q <= sync2;
            rst1  <= {soft_reset_trap, hard_reset_input};
            rst2  <= rst1;
        end
    end

    // ****************************************
    // flag and mask registers
    // ****************************************
    logic [NSRC-1:0] rise;
    logic [NSRC-1:0] next_flag;
    logic [NSRC-1:0] next_mask;
    logic            take;
    logic [NSRC-1:0] take_bit;

    assign rise = sync2 & ~src_q & IRQ_BITS;

    always_comb begin
        next_flag = irq_flag_reg;
        next_mask = irq_mask_reg;
        if (flag_clr_we)
            next_flag = next_flag & ~flag_clr_data;
        if (take)
            next_flag = next_flag & ~take_bit;
        // a new edge beats a clear in the same cycle
        next_flag = (next_flag | rise) & IRQ_BITS;
        if (mask_we)
            next_mask = mask_wdata & IRQ_BITS;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_flag_reg <= FLAG_RST;
            irq_mask_reg <= MASK_RST;
        end else if (clk_en) begin
            irq_flag_reg <= next_flag;
            irq_mask_reg <= next_mask;
        end
    end

    // ****************************************
    // selection and vector issue
    // ****************************************
    ivp_sel_if sel_bus ();

    // one selector per subsystem instance of this module
    ivp_prio_sel u_sel (
        .s (sel_bus)
    );

    assign sel_bus.active = irq_flag_reg & irq_mask_reg &
                            {NSRC{global_en}};

    ivp_state_e       state;
    ivp_state_e       next_state;
    logic             next_req;
    logic [VEC_W-1:0] next_loc;
    logic [PRI_W-1:0] next_pri;
    logic             next_is_rst;
    logic             rst_hit;

    assign rst_hit = |rst2;

    always_comb begin
        next_state  = state;
        next_req    = vec_req;
        next_loc    = vec_loc;
        next_pri    = vec_pri;
        next_is_rst = vec_is_reset;
        take        = 1'b0;
        take_bit    = '0;
        unique case (state)
            IVP_IDLE: begin
                if (rst_hit) begin
                    // reset outranks everything
                    next_state  = IVP_RESET;
                    next_req    = 1'b1;
                    next_loc    = VEC_RESET;
                    next_pri    = PRI_RESET;
                    next_is_rst = 1'b1;
                end else if (sel_bus.hit) begin
                    next_state  = IVP_SERVE;
                    next_req    = 1'b1;
                    // fixed table lookup, never a reserved slot
                    next_loc    = VEC_TAB[sel_bus.idx];
                    next_pri    = PRI_TAB[sel_bus.idx];
                    next_is_rst = 1'b0;
                    take        = 1'b1;
                    take_bit    = NSRC'(1) << sel_bus.idx;
                end
            end
            IVP_RESET, IVP_SERVE: begin
                // request stands until the core fetches the vector
                if (vec_ack) begin
                    next_state  = IVP_IDLE;
                    next_req    = 1'b0;
                    next_pri    = PRI_NONE;
                    next_is_rst = 1'b0;
                end
            end
            default: begin
                next_state = IVP_IDLE;
                next_req   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state        <= IVP_IDLE;
            vec_req      <= 1'b0;
            vec_loc      <= VEC_RESET;
            vec_pri      <= PRI_NONE;
            vec_is_reset <= 1'b0;
        end else if (clk_en) begin
            state        <= next_state;
            vec_req      <= next_req;
            vec_loc      <= next_loc;
            vec_pri      <= next_pri;
            vec_is_reset <= next_is_rst;
        end
    end
endmodule
`default_nettype wire

// *** testbench/interrupt_vector_priority_map_bench.sv ***
`default_nettype none
module interrupt_vector_priority_map_bench
    import ivp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [6:0] loc; logic [4:0] pri; } ivp_row_s;
    // row index is the source pin in port order, ext0 first, dma5 last
    ivp_row_s rows [18] = '{'{7'h40,5'h03}, '{7'h44,5'h04}, '{7'h48,5'h05},
        '{7'h4c,5'h06}, '{7'h50,5'h07}, '{7'h54,5'h08}, '{7'h58,5'h09},
        '{7'h5c,5'h0a}, '{7'h60,5'h0b}, '{7'h64,5'h0c}, '{7'h68,5'h0d},
        '{7'h6c,5'h0e}, '{7'h58,5'h09}, '{7'h5c,5'h0a}, '{7'h68,5'h0d},
        '{7'h6c,5'h0e}, '{7'h70,5'h0f}, '{7'h74,5'h10}};
    logic [6:0] order [4] = '{7'h44, 7'h4c, 7'h70, 7'h74};
    logic clock = 1'b0, resetn = 1'b0, slow = 1'b0, global_en = 1'b1;
    logic mask_we = 1'b0, flag_clr_we = 1'b0, clk_en = 1'b1;
    logic [1:0] rst_in = 2'b00;
    logic [17:0] src = '0;
    logic [NSRC-1:0] mask_wdata = '0, flag_clr_data = '0;
    logic [NSRC-1:0] irq_flag_reg, irq_mask_reg;
    logic vec_ack, vec_req, vec_is_reset;
    logic [VEC_W-1:0] vec_loc;
    logic [PRI_W-1:0] vec_pri;
    int err_count = 0, n_checks = 0;
    always #2.5 clock = ~clock;
    ivp_top dut_u (.clock, .resetn, .clk_en,
        .hard_reset_input(rst_in[0]), .soft_reset_trap(rst_in[1]),
        .ext0_irq(src[0]), .watchdog_irq(src[1]), .ext2_irq(src[2]),
        .timer_irq(src[3]), .port0_receive_irq(src[4]),
        .port0_transmit_irq(src[5]), .port2_receive_irq(src[6]),
        .port2_second_irq(src[7]), .ext3_irq(src[8]),
        .host_to_core_irq_bit(src[9]), .port1_receive_irq(src[10]),
        .port1_transmit_irq(src[11]), .dma_ch0_irq(src[12]),
        .dma_ch1_irq(src[13]), .dma_ch2_irq(src[14]), .dma_ch3_irq(src[15]),
        .dma_ch4_irq(src[16]), .dma_ch5_irq(src[17]), .mask_we, .mask_wdata,
        .flag_clr_we, .flag_clr_data, .global_en, .vec_ack, .irq_flag_reg,
        .irq_mask_reg, .vec_req, .vec_loc, .vec_pri, .vec_is_reset);
    ivp_core_model core_u (.clock, .resetn, .slow, .vec_req, .vec_ack);
    // ********
    // helpers
    // ********
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_req(input logic lvl);
        for (int i = 0; i < 40 && vec_req !== lvl; i++) tick(1);
        if (vec_req !== lvl) begin
            err_count++;
            summarize();
        end
    endtask
    task automatic pulse(input int i);
        @(posedge clock) src[i] <= 1'b1;
        @(posedge clock) src[i] <= 1'b0;
    endtask
    task automatic wr_mask(input logic [15:0] m);
        @(posedge clock) begin mask_we <= 1'b1; mask_wdata <= m; end
        @(posedge clock) mask_we <= 1'b0;
        tick(1);
    endtask
    // ********
    // sequence
    // ********
    initial begin
        tick(12);
        chk(vec_pri, 16'h1f);
        @(posedge clock) resetn <= 1'b1;
        wr_mask(16'hffff);
        chk(irq_mask_reg, 16'h3fff);
        for (int r = 0; r < 18; r++) begin
            pulse(r);
            wait_req(1'b1);
            chk(vec_loc, rows[r].loc);
            chk(vec_pri, rows[r].pri);
            wait_req(1'b0);
        end
        $display("test map done");
        wr_mask(16'h0000);
        pulse(1); pulse(3); pulse(16); pulse(17);
        tick(6);
        chk(irq_flag_reg, 16'h300a);
        @(posedge clock) begin global_en <= 1'b0; slow <= 1'b1; end
        wr_mask(16'h300a);
        tick(4);
        chk(vec_req, 1'b0);
        @(posedge clock) global_en <= 1'b1;
        foreach (order[k]) begin
            wait_req(1'b1);
            chk(vec_loc, order[k]);
            wait_req(1'b0);
        end
        $display("test priority done");
        wr_mask(16'h3fff);
        for (int j = 0; j < 2; j++) begin
            @(posedge clock) begin rst_in[j] <= 1'b1; src[4] <= 1'b1; end
            @(posedge clock) begin rst_in[j] <= 1'b0; src[4] <= 1'b0; end
            wait_req(1'b1);
            chk({vec_is_reset, vec_loc, vec_pri}, 16'h1001);
            wait_req(1'b0);
            wait_req(1'b1);
            chk(vec_loc, 16'h50);
            wait_req(1'b0);
        end
        $display("test reset done");
        wr_mask(16'h0000);
        pulse(11);
        tick(5);
        chk(irq_flag_reg, 16'h0800);
        @(posedge clock) begin flag_clr_we <= 1'b1; flag_clr_data <= 16'h0800; end
        @(posedge clock) flag_clr_we <= 1'b0;
        tick(1);
        chk(irq_flag_reg, 16'h0000);
        // a low clock enable must hold every register, the mask included
        @(posedge clock) clk_en <= 1'b0;
        wr_mask(16'h00ff);
        chk(irq_mask_reg, 16'h0000);
        @(posedge clock) clk_en <= 1'b1;
        wr_mask(16'h1234);
        @(posedge clock) resetn <= 1'b0;
        tick(1);
        chk(irq_mask_reg, 16'h0000);
        @(posedge clock) resetn <= 1'b1;
        tick(2);
        chk({irq_flag_reg[13:0], vec_req, vec_is_reset}, 16'h0000);
        chk(vec_pri, 16'h1f);
        $display("test clear done");
        summarize();
    end
endmodule
`default_nettype wire

// *** testbench/ivp_chk_sva.sv ***
`default_nettype none
module ivp_chk
    import ivp_pkg::*;
(
    input wire logic             clock,
    input wire logic             resetn,
    input wire logic             clk_en,
    input wire logic             mask_we,
    input wire logic [NSRC-1:0]  mask_wdata,
    input wire logic             vec_ack,
    input wire logic [NSRC-1:0]  irq_flag_reg,
    input wire logic [NSRC-1:0]  irq_mask_reg,
    input wire logic             vec_req,
    input wire logic [VEC_W-1:0] vec_loc,
    input wire logic [PRI_W-1:0] vec_pri,
    input wire logic             vec_is_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // vector map
    // ********
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_rst_vec;
        vec_req && vec_is_reset |-> vec_loc == 7'h00 && vec_pri == 5'h01;
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("bad reset vector");
    // bit index sits in loc[5:2], so priority is index plus three
    property p_pri_map;
        vec_req && !vec_is_reset |->
            vec_loc[6] && vec_loc[1:0] == 2'h0 && vec_pri == vec_loc[5:2] + 5'h03;
    endproperty
    a_pri_map: assert property (p_pri_map) else $error("bad priority");
    property p_no_rsv; vec_req |-> vec_loc < 7'h78; endproperty
    a_no_rsv: assert property (p_no_rsv) else $error("reserved vector");
    property p_lowest;
        $rose(vec_req) && !vec_is_reset |->
            ($past(irq_flag_reg & irq_mask_reg) & ((16'h2 << vec_loc[5:2]) - 16'h1))
            == (16'h1 << vec_loc[5:2]);
    endproperty
    a_lowest: assert property (p_lowest) else $error("not lowest pending");
    property p_hold;
        vec_req && !vec_ack |=> vec_req && $stable(vec_loc) && $stable(vec_pri);
    endproperty
    a_hold: assert property (p_hold) else $error("request not held");
    property p_ack;
        vec_req && vec_ack && clk_en |=> !vec_req && vec_pri == 5'h1f;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not honoured");
    property p_mask_wr;
        mask_we && clk_en |=> irq_mask_reg == ($past(mask_wdata) & 16'h3fff);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write");
    property p_rsv_bits; ((irq_flag_reg | irq_mask_reg) & 16'hc000) == 16'h0; endproperty
    a_rsv_bits: assert property (p_rsv_bits) else $error("bits 15:14 set");
    // a low clock enable freezes the flags, the mask, the request and the vector location
    property p_freeze;
        !clk_en |=> $stable(irq_flag_reg) && $stable(irq_mask_reg) &&
            $stable(vec_req) && $stable(vec_loc);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    c_rst: cover property (vec_req && vec_is_reset);
    c_shared: cover property (vec_req && vec_loc == 7'h58);
    c_ack: cover property (vec_req && vec_ack);
endmodule
bind ivp_top ivp_chk chk_u (.clock, .resetn, .clk_en, .mask_we, .mask_wdata,
    .vec_ack, .irq_flag_reg, .irq_mask_reg, .vec_req, .vec_loc, .vec_pri,
    .vec_is_reset);
`default_nettype wire

// *** testbench/ivp_core_model.sv ***
`default_nettype none
module ivp_core_model (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic slow,
    input  wire logic vec_req,
    output var  logic vec_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    // ********
    // fetch side
    // ********
    // a slow core stalls three cycles before taking the vector
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            vec_ack  <= 1'b0;
            wait_cnt <= 2'd0;
        end else begin
            vec_ack  <= vec_req && !vec_ack && (!slow || wait_cnt == 2'd3);
            wait_cnt <= (vec_req && !vec_ack) ? wait_cnt + 2'd1 : 2'd0;
        end
    end
endmodule
`default_nettype wire
